//--- rtl/mms_pkg.sv
// Package for the module management status and timing block.
// Assumes a 100 MHz system clock and a 1 us prescaled tick.
//Contract
//(RULE_01) Management bus answers within 2000 ms of power becoming valid.
//(RULE_02) Within 2000 ms of power, clear data-not-ready and assert interrupt.
//(RULE_03) After reset input rises, become fully functional within 2000 ms.
//(RULE_04) Fully functional means interrupt asserted because data-not-ready cleared.
//(RULE_05) Low-power input high drops consumption to level 1 within 100 us.
//(RULE_06) Low-power input low makes the device fully functional within 300 ms.
//(RULE_07) Interrupt output goes low within 200 ms of any trigger condition.
//(RULE_08) Flags clear on read; interrupt releases within 500 us of last clear.
//(RULE_09) Receive signal loss sets its flag and interrupt within 100 ms.
//(RULE_10) Transmit fault sets its flag and interrupt within 200 ms.
//(RULE_11) Any other condition sets its flag and interrupt within 200 ms.
//(RULE_12) Mask bit written to 1 inhibits its interrupt within 100 ms.
//(RULE_13) Mask bit written to 0 resumes its interrupt within 100 ms.
//(RULE_14) Rate or application select change takes effect within 100 us.
//(RULE_15) Power-down override written to 1 enters power level 1 within 100 ms.
//(RULE_16) Power-down override written to 0 fully functional within 300 ms.
//(RULE_17) Write and read timing counts from bus clock fall after stop.
//(RULE_18) Reset input held low past minimum pulse is recognised within 2 us.
//(RULE_19) Interrupt low while any unmasked latched flag is set, else released.
//(RULE_20) All ms and us timeouts come from a prescaled tick of the clock; the reset pin filter counts clock cycles instead.
package mms_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int T_SERIAL_MS = 2000;
  localparam int T_DATA_MS = 2000;
  localparam int T_RESET_MS = 2000;
  localparam int T_LP_ON_US = 100;
  localparam int T_LP_OFF_MS = 300;
  localparam int T_IRQ_ON_MS = 200;
  localparam int T_IRQ_OFF_US = 500;
  localparam int T_LOS_MS = 100;
  localparam int T_TXF_MS = 200;
  localparam int T_FLAG_MS = 200;
  localparam int T_MASK_ON_MS = 100;
  localparam int T_MASK_OFF_MS = 100;
  localparam int T_RATESEL_US = 100;
  localparam int T_PDOWN_ON_MS = 100;
  localparam int T_PDOWN_OFF_MS = 300;
  localparam int T_RESET_RECOG_US = 2;
  // Margin for synchroniser delay and tick phase
  localparam int GUARD_TICKS = 2;
  localparam int INIT_TICKS_DEF = T_DATA_MS * US_PER_MS - GUARD_TICKS;
  localparam int WAKE_TICKS_DEF = T_LP_OFF_MS * US_PER_MS - GUARD_TICKS;
  // Half the recognition time, leaving room for the synchroniser
  localparam int RESET_FILT_CYCLES = T_RESET_RECOG_US * TICK_NS / CLK_PERIOD_NS / 2;
  localparam int CNT_W = 22;
  localparam int FILT_W = 8;
  localparam int FLAG_READY = 0;
  localparam int FLAG_LOS = 1;
  localparam int FLAG_TXF = 2;
  localparam logic RST_FLAG_BIT = 1'b0;
  localparam logic RST_MASK_BIT = 1'b0;
  localparam logic RST_RATE_BIT = 1'b0;
  localparam logic RST_PDOWN = 1'b0;
  localparam logic RST_PIN_HIGH = 1'b1;
  localparam logic RST_PIN_LOW = 1'b0;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN = 2'b10,
    ST_LOWPWR = 2'b11
  } mms_state_t;
endpackage

//--- rtl/mms_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
module mms_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule

//--- rtl/mms_tick.sv
// Prescaler producing a one-cycle pulse every microsecond.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/1ps
module mms_tick
  import mms_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  mms_time_if.src tm
);
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic wrap;
  assign wrap = (div_q == 8'(DIV - 1)); // RULE_20
  assign div_d = wrap ? 8'h00 : div_q + 8'h01;
  assign tm.tick_us = wrap;
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      div_q <= 8'h00;
    else
      div_q <= div_d;
  end
endmodule

//--- rtl/mms_time_if.sv
// Interface carrying the microsecond tick between block modules.
// Assumes both ends share i_clock.
`timescale 1ns/1ps
interface mms_time_if;
  logic tick_us;
  modport src (output tick_us);
  modport dst (input tick_us);
endinterface

//--- rtl/mms_top.sv
// Management status, interrupt and power-control timing of the module.
// Assumes a serial slave on i_clock giving stop pulses and written fields;
// pins and condition inputs arrive asynchronously.
`timescale 1ns/1ps
module mms_top
  import mms_pkg::*;
#(
  parameter int NUM_FLAGS = 8,
  parameter int RATE_W = 4,
  parameter int INIT_TICKS = INIT_TICKS_DEF,
  parameter int WAKE_TICKS = WAKE_TICKS_DEF
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_reset_in_n,
  input wire logic i_low_power_request,
  input wire logic i_bus_scl,
  input wire logic [NUM_FLAGS-1:1] i_condition,
  input wire logic i_write_stop,
  input wire logic [NUM_FLAGS-1:0] i_wr_mask,
  input wire logic i_wr_pdown,
  input wire logic [RATE_W-1:0] i_wr_rate,
  input wire logic i_read_stop,
  input wire logic [NUM_FLAGS-1:0] i_read_clear,
  input wire logic i_interrupt_out_n_i,
  output logic o_interrupt_out_n_o,
  output logic o_interrupt_out_n_oe_n,
  output logic o_interrupt_line_low,
  output logic o_bus_ready,
  output logic o_data_not_ready,
  output logic o_fully_functional,
  output logic o_power_level1,
  output logic [RATE_W-1:0] o_rate_select,
  output logic [NUM_FLAGS-1:0] o_flags,
  output logic [NUM_FLAGS-1:0] o_mask,
  output logic o_pdown
);
  localparam int SYNC_W = NUM_FLAGS + 3;

  mms_time_if tm ();

  mms_tick u_tick (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .tm(tm)
  );

  // Pin levels, all through two flops before use
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  assign pins_raw = {i_condition, i_interrupt_out_n_i, i_bus_scl,
                     i_low_power_request, i_reset_in_n};

  mms_sync #(
    .W(SYNC_W),
    .RST_VAL({{(NUM_FLAGS - 1){RST_PIN_LOW}}, RST_PIN_HIGH, RST_PIN_HIGH,
              RST_PIN_LOW, RST_PIN_HIGH})
  ) u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  logic rstn_s;
  logic lp_s;
  logic scl_s;
  logic irq_pin_s;
  logic [NUM_FLAGS-1:1] cond_s;
  assign rstn_s = pins_s[0];
  assign lp_s = pins_s[1];
  assign scl_s = pins_s[2];
  assign irq_pin_s = pins_s[3];
  assign cond_s = pins_s[SYNC_W-1:4];

  // Reset pin filter: short glitches never reset the module
  logic [FILT_W-1:0] filt_q;
  logic [FILT_W-1:0] filt_d;
  logic mod_rst_q;
  logic mod_rst_d;
  logic filt_hit;
  assign filt_hit = (filt_q == FILT_W'(RESET_FILT_CYCLES)); // RULE_18
  assign filt_d = rstn_s ? '0 : (filt_hit ? filt_q : filt_q + FILT_W'(1));
  assign mod_rst_d = rstn_s ? 1'b0 : (filt_hit | mod_rst_q); // RULE_18

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      filt_q <= '0;
      mod_rst_q <= 1'b0;
    end
    else
    begin
      filt_q <= filt_d;
      mod_rst_q <= mod_rst_d;
    end
  end

  // Bus clock falling edge marks the start of write and read timing
  logic scl_prev_q;
  logic scl_fall;
  assign scl_fall = scl_prev_q & ~scl_s; // RULE_17

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      scl_prev_q <= RST_PIN_HIGH;
    else
      scl_prev_q <= scl_s;
  end

  // Writes and clearing reads wait for that edge before acting
  logic wr_pend_q;
  logic rd_pend_q;
  logic [NUM_FLAGS-1:0] pend_mask_q;
  logic pend_pdown_q;
  logic [RATE_W-1:0] pend_rate_q;
  logic [NUM_FLAGS-1:0] pend_clr_q;
  logic wr_apply;
  logic rd_apply;
  assign wr_apply = wr_pend_q & scl_fall; // RULE_17
  assign rd_apply = rd_pend_q & scl_fall; // RULE_17

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      pend_mask_q <= {NUM_FLAGS{RST_MASK_BIT}};
      pend_pdown_q <= RST_PDOWN;
      pend_rate_q <= {RATE_W{RST_RATE_BIT}};
      pend_clr_q <= '0;
    end
    else
    begin
      wr_pend_q <= i_write_stop | (wr_pend_q & ~scl_fall);
      rd_pend_q <= i_read_stop | (rd_pend_q & ~scl_fall);
      if (i_write_stop)
      begin
        pend_mask_q <= i_wr_mask;
        pend_pdown_q <= i_wr_pdown;
        pend_rate_q <= i_wr_rate;
      end
      // Back-to-back reads merge their clear sets
      if (i_read_stop)
        pend_clr_q <= i_read_clear | (rd_apply ? '0 : pend_clr_q);
      else if (rd_apply)
        pend_clr_q <= '0;
    end
  end

  // Written controls take effect on the edge itself
  logic [NUM_FLAGS-1:0] mask_q;
  logic pdown_q;
  logic [RATE_W-1:0] rate_q;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      mask_q <= {NUM_FLAGS{RST_MASK_BIT}};
      pdown_q <= RST_PDOWN;
      rate_q <= {RATE_W{RST_RATE_BIT}};
    end
    else if (wr_apply)
    begin
      mask_q <= pend_mask_q; // RULE_12 RULE_13
      pdown_q <= pend_pdown_q; // RULE_15 RULE_16
      rate_q <= pend_rate_q; // RULE_14
    end
  end

  // Low power: pin request or software override
  logic lp_active;
  assign lp_active = lp_s | pdown_q;

  // Readiness state machine and its microsecond countdown
  mms_state_t state_q;
  mms_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic cnt_zero;
  logic init_done;
  logic dnr_q;
  logic dnr_d;
  logic bus_rdy_q;
  assign cnt_zero = (cnt_q == '0);
  assign init_done = (state_q == ST_INIT) & cnt_zero & ~mod_rst_q;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    dnr_d = dnr_q;
    if (mod_rst_q)
    begin
      state_d = ST_HOLD;
      dnr_d = 1'b1;
    end
    else
    begin
      unique case (state_q)
        ST_HOLD:
        begin
          // Reset input released: restart the power-up wait
          state_d = ST_INIT;
          cnt_d = CNT_W'(INIT_TICKS); // RULE_03
        end
        ST_INIT:
        begin
          if (cnt_zero)
          begin
            dnr_d = 1'b0; // RULE_02 RULE_04
            state_d = lp_active ? ST_LOWPWR : ST_RUN;
          end
          else if (tm.tick_us)
            cnt_d = cnt_q - CNT_W'(1); // RULE_20
        end
        ST_RUN:
        begin
          if (lp_active)
            state_d = ST_LOWPWR; // RULE_05 RULE_15
        end
        ST_LOWPWR:
        begin
          if (!lp_active)
          begin
            // Wake goes through a fresh not-ready cycle
            state_d = ST_INIT;
            dnr_d = 1'b1;
            cnt_d = CNT_W'(WAKE_TICKS); // RULE_06 RULE_16
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      // Power-on counts as a release of reset
      state_q <= ST_INIT;
      cnt_q <= CNT_W'(INIT_TICKS); // RULE_01 RULE_02
      dnr_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dnr_q <= dnr_d;
    end
  end

  // Bus answers from the first completed wait until power is lost
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      bus_rdy_q <= 1'b0;
    else if (init_done)
      bus_rdy_q <= 1'b1; // RULE_01
  end

  // Condition entry detection
  logic [NUM_FLAGS-1:1] cond_prev_q;
  logic [NUM_FLAGS-1:0] set_ev;
  assign set_ev[FLAG_READY] = init_done; // RULE_04

  genvar g;
  generate
    for (g = 1; g < NUM_FLAGS; g++)
    begin : g_cond
      // Entry into loss, fault or other state
      assign set_ev[g] = cond_s[g] & ~cond_prev_q[g]; // RULE_09 RULE_10 RULE_11
    end
  endgenerate

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      cond_prev_q <= '0;
    else
      cond_prev_q <= cond_s;
  end

  // Latched flags: set beats a clear landing in the same cycle
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] flags_d;
  logic [NUM_FLAGS-1:0] clr_now;
  assign clr_now = rd_apply ? pend_clr_q : '0; // RULE_08 RULE_17
  assign flags_d = (flags_q & ~clr_now) | set_ev; // RULE_08 RULE_09 RULE_10 RULE_11

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      flags_q <= {NUM_FLAGS{RST_FLAG_BIT}};
    else
      flags_q <= flags_d;
  end

  // Interrupt follows unmasked flags in the same cycle as the flag register; a mask change reaches it one cycle later
  logic irq_d;
  logic irq_q;
  logic line_low_q;
  assign irq_d = |(flags_d & ~mask_q); // RULE_19 RULE_07 RULE_12 RULE_13

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      irq_q <= 1'b0;
      line_low_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d; // RULE_07 RULE_08 RULE_19
      line_low_q <= ~irq_pin_s;
    end
  end

  // Power level follows the request at once; no ramp is modelled
  logic pl1_q;
  logic ff_q;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      pl1_q <= 1'b0;
      ff_q <= 1'b0;
    end
    else
    begin
      pl1_q <= lp_active; // RULE_05 RULE_15
      ff_q <= (state_d == ST_RUN) & ~dnr_d; // RULE_04 RULE_06 RULE_16
    end
  end

  // Open-drain interrupt: only ever pulls low
  assign o_interrupt_out_n_o = 1'b0;
  assign o_interrupt_out_n_oe_n = ~irq_q;
  assign o_interrupt_line_low = line_low_q;
  assign o_bus_ready = bus_rdy_q;
  assign o_data_not_ready = dnr_q;
  assign o_fully_functional = ff_q;
  assign o_power_level1 = pl1_q;
  assign o_rate_select = rate_q;
  assign o_flags = flags_q;
  assign o_mask = mask_q;
  assign o_pdown = pdown_q;
endmodule

//--- testbench/mms_chk.sv
// Checker of interrupt, readiness and power-level timing at the block ports.
// Assumes bind to mms_top; flag bit 1 is receive loss, bit 2 transmit fault.
`timescale 1ns/1ps
module mms_chk
#(
  parameter int NUM_FLAGS = 8
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_reset_in_n,
  input wire logic i_low_power_request,
  input wire logic [NUM_FLAGS-1:1] i_condition,
  input wire logic o_interrupt_out_n_o,
  input wire logic o_interrupt_out_n_oe_n,
  input wire logic o_bus_ready,
  input wire logic o_data_not_ready,
  input wire logic o_fully_functional,
  input wire logic o_power_level1,
  input wire logic [NUM_FLAGS-1:0] o_flags,
  input wire logic [NUM_FLAGS-1:0] o_mask
);
  logic [NUM_FLAGS-1:0] mask_prev_q;
  logic [7:0] low_cnt_q;
  // Mask takes one extra cycle to reach the enable
  wire irq_want = |(o_flags & ~mask_prev_q);
  wire irq_ok = o_interrupt_out_n_oe_n != irq_want;
  always_ff @(posedge i_clock)
  begin
    mask_prev_q <= i_sys_rst ? '0 : o_mask;
    if (i_sys_rst || i_reset_in_n)
      low_cnt_q <= 8'h00;
    else if (low_cnt_q != 8'hFF)
      low_cnt_q <= low_cnt_q + 8'h01;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_od_data_low: assert property (o_interrupt_out_n_o == 1'b0)
    else $error("interrupt data not low");
  a_irq_tracks_flags: assert property (irq_ok)
    else $error("interrupt enable disagrees with flags");
  a_los_flag_set: assert property
    ((!i_condition[1] ##1 i_condition[1] [*4]) |-> o_flags[1])
    else $error("receive loss flag late");
  a_txf_flag_set: assert property
    ((!i_condition[2] ##1 i_condition[2] [*4]) |-> o_flags[2])
    else $error("transmit fault flag late");
  a_lp_level_one: assert property (i_low_power_request [*5] |-> o_power_level1)
    else $error("low power level late");
  a_bus_ready_held: assert property (o_bus_ready |=> o_bus_ready)
    else $error("bus ready dropped");
  a_ready_flag_set: assert property
    ($fell(o_data_not_ready) |-> ##[0:1] (o_flags[0] && o_bus_ready))
    else $error("ready flag missing");
  a_ff_needs_ready: assert property (o_fully_functional |-> !o_data_not_ready)
    else $error("functional while not ready");
  a_lp_not_ff: assert property (o_power_level1 |=> !o_fully_functional)
    else $error("functional in low power");
  a_pin_reset_seen: assert property
    (low_cnt_q == 8'h78 |-> o_data_not_ready && !o_fully_functional)
    else $error("reset pin not recognised");
endmodule
bind mms_top mms_chk #(.NUM_FLAGS(NUM_FLAGS)) u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_reset_in_n(i_reset_in_n), .i_low_power_request(i_low_power_request),
  .i_condition(i_condition), .o_interrupt_out_n_o(o_interrupt_out_n_o),
  .o_interrupt_out_n_oe_n(o_interrupt_out_n_oe_n), .o_bus_ready(o_bus_ready),
  .o_data_not_ready(o_data_not_ready), .o_fully_functional(o_fully_functional),
  .o_power_level1(o_power_level1), .o_flags(o_flags), .o_mask(o_mask));

//--- testbench/mms_host_model.sv
// Host-side model: serial bus clock bursts and the pulled-up interrupt wire.
// Assumes the bench pulses i_frame right after each write or read stop strobe.
`timescale 1ns/1ps
module mms_host_model
(
  input wire logic i_frame,
  input wire logic i_oe_n,
  output logic o_scl,
  output logic o_line
);
  // Pull-up wins unless the device pulls low
  assign o_line = i_oe_n ? 1'b1 : 1'b0;
  // Clock stands high between frames, 125 ns period inside
  initial
  begin
    o_scl = 1'b1;
    forever
    begin
      @(posedge i_frame);
      repeat (4)
      begin
        #62.5 o_scl = 1'b0;
        #62.5 o_scl = 1'b1;
      end
    end
  end
endmodule

//--- testbench/test_module_mgmt_status_timing.sv
// Self-checking bench for the management status and timing block.
// Assumes shortened init and wake counts; host model supplies bus clock and wire.
`timescale 1ns/1ps
module test_module_mgmt_status_timing;
  import mms_pkg::*;
  logic clk = 0, rst = 1, rst_n = 1, lp = 0, frame = 0, scl, line, wstop = 0, pd = 0, rstop = 0;
  logic [7:1] cond = '0;
  logic [7:0] wmask = '0, rclr = '0, lf = 8'h1C;
  logic [3:0] wrate = '0;
  logic od, oe_n, llow, brdy, nrdy, ff, pl1, opd;
  logic [3:0] rate;
  logic [7:0] flags, mask;
  int failures = 0, compares = 0, cycles = 0, b;
  mms_top #(.NUM_FLAGS(8), .RATE_W(4), .INIT_TICKS(20), .WAKE_TICKS(10)) dut (.i_clock(clk),
    .i_sys_rst(rst), .i_reset_in_n(rst_n), .i_low_power_request(lp), .i_bus_scl(scl),
    .i_condition(cond), .i_write_stop(wstop), .i_wr_mask(wmask), .i_wr_pdown(pd),
    .i_wr_rate(wrate), .i_read_stop(rstop), .i_read_clear(rclr), .i_interrupt_out_n_i(line),
    .o_interrupt_out_n_o(od), .o_interrupt_out_n_oe_n(oe_n), .o_interrupt_line_low(llow),
    .o_bus_ready(brdy), .o_data_not_ready(nrdy), .o_fully_functional(ff),
    .o_power_level1(pl1), .o_rate_select(rate), .o_flags(flags), .o_mask(mask), .o_pdown(opd));
  mms_host_model host (.i_frame(frame), .i_oe_n(oe_n), .o_scl(scl), .o_line(line));
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic summarize();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send_frame();
    frame = 1;
    step(1);
    frame = 0;
    step(60);
  endtask
  task automatic wr(input logic [7:0] m, input logic p);
    lf = lfsr(lf);
    wmask = m;
    pd = p;
    wrate = lf[3:0];
    wstop = 1;
    step(1);
    wstop = 0;
    send_frame();
    chk(9'(mask), 9'(m));
    chk(9'(rate), 9'(lf[3:0]));
    chk(9'(opd), 9'(p));
  endtask
  task automatic rd(input logic [7:0] c);
    rclr = c;
    rstop = 1;
    step(1);
    rstop = 0;
    send_frame();
  endtask
  task automatic wait_ff(input int max);
    int n;
    n = 0;
    while (ff !== 1'b1 && n < max)
    begin
      step(1);
      n++;
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    // Longest legal sequence stays well below this
    if (cycles == 30000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    step(1);
    chk(9'({od, oe_n, llow, nrdy, brdy, ff}), 9'h014);
    step(1);
    rst = 0;
    wait_ff(2300);
    chk(9'({nrdy, flags[0], brdy, ff}), 9'h007);
    // Readback passes two sync flops and one output flop
    step(3);
    chk(9'({oe_n, llow}), 9'h001);
    rd(8'h01);
    chk({flags, oe_n}, 9'h001);
    for (int i = 0; i < 8; i++)
    begin
      lf = lfsr(lf);
      b = i < 2 ? i + 1 : int'(lf % 7) + 1;
      cond[b] = 1;
      step(5);
      chk(9'(flags), 9'(8'h01 << b));
      chk(9'(oe_n), 9'h000);
      rd(8'h01 << b);
      chk({flags, oe_n}, 9'h001);
      cond[b] = 0;
      step(2);
    end
    wr(8'hFF, 0);
    cond[1] = 1;
    step(5);
    chk({flags, oe_n}, 9'h005);
    wr(8'h00, 0);
    chk(9'(oe_n), 9'h000);
    rd(8'h02);
    chk(9'(oe_n), 9'h001);
    cond[1] = 0;
    wr(8'h00, 1);
    chk(9'({pl1, ff}), 9'h002);
    wr(8'h00, 0);
    wait_ff(1300);
    chk(9'({pl1, ff}), 9'h001);
    rd(8'h01);
    lp = 1;
    step(5);
    chk(9'({pl1, ff}), 9'h002);
    lp = 0;
    wait_ff(1300);
    chk(9'({pl1, ff}), 9'h001);
    rd(8'h01);
    rst_n = 0;
    step(120);
    chk(9'({nrdy, ff}), 9'h002);
    rst_n = 1;
    wait_ff(2300);
    chk(9'({nrdy, ff, brdy}), 9'h003);
    step(2);
    chk(9'(oe_n), 9'h000);
    summarize();
  end
endmodule
